/* shared/lps_map.svh */
// constants and rule overview for the lcd power save sequencer
// ==========================================================================
// Overview of operation
// - after power save is requested the panel completes one blank frame before sleep.
// - configuration registers keep their contents for the whole low-power state.
// - display memory control outputs hold their current levels while in low power.
// - clearing the power save enable level leaves low power and resumes normal operation.
// - in indirect mode the power save command is a single byte with no parameters.
// - in indirect mode the system configuration command leaves low power.
// - the panel display disable goes low within one to two frames of the request.
// - the internal clock enable stays off while low power is in effect; the oscillator restarts when exit begins.
// - panel outputs are low in power save and display off, and active with display on.
// - register accesses are always taken, memory accesses are refused in low power.
`ifndef LPS_MAP_SVH
`define LPS_MAP_SVH

// ==========================================================================
// command codes (indirect mode)
`define LPS_CMD_POWER_SAVE  8'hF0
`define LPS_CMD_SYSTEM_SET  8'hF1

// ==========================================================================
// timing counts
`define LPS_BLANK_FRAMES    2'h1

// ==========================================================================
// reset values
`define LPS_MEM_CTRL_RST    4'h0
`define LPS_PANEL_DATA_RST  6'h00
`define LPS_OSC_RUN_RST     1'b1
`define LPS_CLK_EN_RST      1'b1

`endif

/* shared/lps_pkg.sv */
// types for the lcd power save sequencer
package lps_pkg;

  // ========================================================================
  // state machines
  typedef enum logic [3:0] {
    LPS_M_RUN   = 4'h1,
    LPS_M_ENTER = 4'h2,
    LPS_M_SLEEP = 4'h4,
    LPS_M_EXIT  = 4'h8
  } lps_mstate_t;

  typedef enum logic [3:0] {
    LPS_P_RUN   = 4'h1,
    LPS_P_DRAIN = 4'h2,
    LPS_P_BLANK = 4'h4,
    LPS_P_SLEEP = 4'h8
  } lps_pstate_t;

  // ========================================================================
  // system clock domain state
  typedef struct packed {
    lps_mstate_t state;
    logic        ps_cmd;
    logic        req;
    logic        ack_s1;
    logic        ack_s2;
    logic        osc_run;
    logic        clk_en;
    logic        cfg_retain;
    logic [3:0]  mem_ctrl;
    logic        mem_ack;
    logic        mem_refuse;
    logic        reg_ack;
  } lps_mclk_t;

  // ========================================================================
  // panel clock domain state
  typedef struct packed {
    lps_pstate_t state;
    logic [1:0]  frame_cnt;
    logic        req_s1;
    logic        req_s2;
    logic        don_s1;
    logic        don_s2;
    logic        ack;
    logic        disp_disable;
    logic        shift_clk;
    logic        frame_pulse;
    logic        line_pulse;
    logic        drive_ready;
    logic [5:0]  data_bus;
  } lps_pclk_t;

endpackage

/* rtl/lps_power_save.sv */
// power save sequencer: host side on the system clock, panel side on the panel clock
`timescale 1ns/1ns
`include "lps_map.svh"

module lps_power_save
  import lps_pkg::*;
(
  // system clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  // host controls
  input  wire logic       i_power_save_en,
  input  wire logic       i_indirect_mode,
  input  wire logic       i_cmd_valid,
  input  wire logic [7:0] i_cmd_byte,
  input  wire logic       i_display_on,
  // host access requests
  input  wire logic       i_reg_req,
  input  wire logic       i_mem_req,
  // display memory control from the memory controller
  input  wire logic [3:0] i_mem_ctrl,
  // panel clock and timing generator
  input  wire logic       i_pclk,
  input  wire logic       i_frame_start,
  input  wire logic       i_gen_shift,
  input  wire logic       i_gen_frame,
  input  wire logic       i_gen_line,
  input  wire logic       i_gen_drdy,
  input  wire logic [5:0] i_gen_data,
  // host side outputs
  output logic            o_reg_ack,
  output logic            o_mem_ack,
  output logic            o_mem_refuse,
  output logic [3:0]      o_mem_ctrl,
  output logic            o_cfg_retain,
  output logic            o_int_clk_en,
  output logic            o_oscillator_run,
  output logic            o_low_power,
  // panel outputs
  output logic            o_panel_display_disable,
  output logic            o_panel_pixel_shift_clock,
  output logic            o_panel_frame_pulse,
  output logic            o_panel_line_pulse,
  output logic            o_panel_drive_ready,
  output logic [5:0]      o_panel_data_bus
);

  // ========================================================================
  // system clock domain
  lps_mclk_t m_r;
  lps_mclk_t m_nxt;
  logic      mem_open;
  // panel state declared up front: the host side reads its ack flop
  lps_pclk_t p_r;
  lps_pclk_t p_nxt;

  always_comb begin
    m_nxt            = m_r;
    // ack from the panel side passes two flops before use
    m_nxt.ack_s1     = p_r.ack;
    m_nxt.ack_s2     = m_r.ack_s1;
    if (i_indirect_mode && i_cmd_valid) begin
      if (i_cmd_byte == `LPS_CMD_POWER_SAVE) begin
        m_nxt.ps_cmd = 1'b1;
      end else if (i_cmd_byte == `LPS_CMD_SYSTEM_SET) begin
        m_nxt.ps_cmd = 1'b0;
      end
    end
    m_nxt.req        = i_power_save_en | m_nxt.ps_cmd;
    case (m_r.state)
      LPS_M_RUN: begin
        // a stale ack from an aborted entry must clear first
        if (m_r.req && !m_r.ack_s2) begin
          m_nxt.state = LPS_M_ENTER;
        end
      end
      LPS_M_ENTER: begin
        if (!m_r.req) begin
          m_nxt.state = LPS_M_RUN;
        end else if (m_r.ack_s2) begin
          m_nxt.state      = LPS_M_SLEEP;
          m_nxt.clk_en     = 1'b0;
          m_nxt.osc_run    = 1'b0;
          m_nxt.cfg_retain = 1'b1;
        end
      end
      LPS_M_SLEEP: begin
        if (!m_r.req) begin
          m_nxt.state   = LPS_M_EXIT;
          m_nxt.osc_run = 1'b1;
        end
      end
      LPS_M_EXIT: begin
        // the internal clock enable returns only once the panel side has left sleep
        if (!m_r.ack_s2) begin
          m_nxt.state      = LPS_M_RUN;
          m_nxt.clk_en     = 1'b1;
          m_nxt.cfg_retain = 1'b0;
        end
      end
      default: begin
        m_nxt.state = LPS_M_RUN;
      end
    endcase
    mem_open         = (m_r.state == LPS_M_RUN) || (m_r.state == LPS_M_ENTER);
    m_nxt.reg_ack    = i_reg_req;
    m_nxt.mem_ack    = i_mem_req & mem_open;
    m_nxt.mem_refuse = i_mem_req & ~mem_open;
    // control levels freeze from the edge that enters sleep
    if (mem_open && (m_nxt.state != LPS_M_SLEEP)) begin
      m_nxt.mem_ctrl = i_mem_ctrl;
    end else begin
      m_nxt.mem_ctrl = m_r.mem_ctrl;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      m_r            <= '0;
      m_r.state      <= LPS_M_RUN;
      m_r.osc_run    <= `LPS_OSC_RUN_RST;
      m_r.clk_en     <= `LPS_CLK_EN_RST;
      m_r.mem_ctrl   <= `LPS_MEM_CTRL_RST;
    end else begin
      m_r <= m_nxt;
    end
  end

  assign o_reg_ack        = m_r.reg_ack;
  assign o_mem_ack        = m_r.mem_ack;
  assign o_mem_refuse     = m_r.mem_refuse;
  assign o_mem_ctrl       = m_r.mem_ctrl;
  assign o_cfg_retain     = m_r.cfg_retain;
  assign o_int_clk_en     = m_r.clk_en;
  assign o_oscillator_run = m_r.osc_run;
  assign o_low_power      = m_r.cfg_retain;

  // ========================================================================
  // panel clock domain
  logic      active;

  always_comb begin
    p_nxt        = p_r;
    // request and display on pass two flops into the panel domain
    p_nxt.req_s1 = m_r.req;
    p_nxt.req_s2 = p_r.req_s1;
    p_nxt.don_s1 = i_display_on;
    p_nxt.don_s2 = p_r.don_s1;
    active       = 1'b0;
    case (p_r.state)
      LPS_P_RUN: begin
        active = 1'b1;
        if (p_r.req_s2) begin
          p_nxt.state = LPS_P_DRAIN;
        end
      end
      LPS_P_DRAIN: begin
        active = 1'b1;
        if (!p_r.req_s2) begin
          p_nxt.state = LPS_P_RUN;
        end else if (i_frame_start) begin
          p_nxt.state     = LPS_P_BLANK;
          p_nxt.frame_cnt = 2'h0;
        end
      end
      LPS_P_BLANK: begin
        if (!p_r.req_s2) begin
          p_nxt.state = LPS_P_RUN;
        end else if (i_frame_start) begin
          p_nxt.frame_cnt = p_r.frame_cnt + 2'h1;
          if ((p_r.frame_cnt + 2'h1) == `LPS_BLANK_FRAMES) begin
            p_nxt.state = LPS_P_SLEEP;
            p_nxt.ack   = 1'b1;
          end
        end
      end
      LPS_P_SLEEP: begin
        if (!p_r.req_s2) begin
          p_nxt.state = LPS_P_RUN;
          p_nxt.ack   = 1'b0;
        end
      end
      default: begin
        p_nxt.state = LPS_P_RUN;
        p_nxt.ack   = 1'b0;
      end
    endcase
    if (active && p_r.don_s2) begin
      p_nxt.disp_disable = 1'b1;
      p_nxt.shift_clk    = i_gen_shift;
      p_nxt.frame_pulse  = i_gen_frame;
      p_nxt.line_pulse   = i_gen_line;
      p_nxt.drive_ready  = i_gen_drdy;
      p_nxt.data_bus     = i_gen_data;
    end else begin
      p_nxt.disp_disable = 1'b0;
      p_nxt.shift_clk    = 1'b0;
      p_nxt.frame_pulse  = 1'b0;
      p_nxt.line_pulse   = 1'b0;
      p_nxt.drive_ready  = 1'b0;
      p_nxt.data_bus     = `LPS_PANEL_DATA_RST;
    end
  end

  always_ff @(posedge i_pclk or posedge i_rst) begin
    if (i_rst) begin
      p_r          <= '0;
      p_r.state    <= LPS_P_RUN;
      p_r.data_bus <= `LPS_PANEL_DATA_RST;
    end else begin
      p_r <= p_nxt;
    end
  end

  assign o_panel_display_disable   = p_r.disp_disable;
  assign o_panel_pixel_shift_clock = p_r.shift_clk;
  assign o_panel_frame_pulse       = p_r.frame_pulse;
  assign o_panel_line_pulse        = p_r.line_pulse;
  assign o_panel_drive_ready       = p_r.drive_ready;
  assign o_panel_data_bus          = p_r.data_bus;

endmodule

/* testbench/lps_panel_gen.sv */
// panel timing generator model, a frame start every eight panel clocks
`timescale 1ns/1ns
module lps_panel_gen (
  // panel clock and reset
  input  wire logic       i_pclk,
  input  wire logic       i_rst,
  // timing outputs
  output logic            o_frame_start,
  output logic [9:0]      o_gen
);
  logic [2:0] cnt_r;
  always @(posedge i_pclk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r <= 3'h0;
      o_frame_start <= 1'b0;
      o_gen <= 10'h000;
    end else begin
      cnt_r <= cnt_r + 3'h1;
      o_frame_start <= (cnt_r == 3'h7);
      o_gen <= 10'($urandom);
    end
  end
endmodule

/* testbench/lps_asserts.sv */
// assertion checker for the lcd power save sequencer
`timescale 1ns/1ns
module lps_asserts (
  // clocks, reset and host side
  input wire logic       i_mclk,
  input wire logic       i_pclk,
  input wire logic       i_rst,
  input wire logic       i_power_save_en,
  input wire logic       i_reg_req,
  input wire logic       i_mem_req,
  input wire logic       o_reg_ack,
  input wire logic       o_mem_refuse,
  input wire logic [3:0] o_mem_ctrl,
  input wire logic       o_cfg_retain,
  input wire logic       o_int_clk_en,
  input wire logic       o_oscillator_run,
  input wire logic       o_low_power,
  // panel side
  input wire logic       o_panel_display_disable,
  input wire logic       o_panel_pixel_shift_clock,
  input wire logic       o_panel_frame_pulse,
  input wire logic       o_panel_line_pulse,
  input wire logic       o_panel_drive_ready,
  input wire logic [5:0] o_panel_data_bus
);
  sequence s_held;
    o_low_power [*2];
  endsequence
  a_reg_ack: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_reg_req |=> o_reg_ack) else $error("reg access not acked");
  a_mem_refuse: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_low_power && i_mem_req |=> o_mem_refuse) else $error("mem access not refused");
  a_mem_hold: assert property (@(posedge i_mclk) disable iff (i_rst)
    s_held |-> $stable(o_mem_ctrl)) else $error("mem control moved");
  a_clk_stop: assert property (@(posedge i_mclk) disable iff (i_rst)
    $rose(o_low_power) |-> ##[0:3] (!o_int_clk_en && !o_oscillator_run))
    else $error("clocks still running");
  a_cfg_kept: assert property (@(posedge i_mclk) disable iff (i_rst)
    !o_int_clk_en |-> o_cfg_retain) else $error("clocks stopped without retain");
  a_blank_first: assert property (@(posedge i_mclk) disable iff (i_rst)
    $rose(o_low_power) |-> !o_panel_display_disable) else $error("no blank frame");
  a_dis_bound: assert property (@(posedge i_pclk) disable iff (i_rst)
    $rose(i_power_save_en) |-> ##[1:20] !o_panel_display_disable)
    else $error("disable late");
  a_panel_low: assert property (@(posedge i_pclk) disable iff (i_rst)
    !o_panel_display_disable |-> !o_panel_pixel_shift_clock && !o_panel_frame_pulse
      && !o_panel_line_pulse && !o_panel_drive_ready && o_panel_data_bus == 6'h00)
    else $error("panel not parked");
endmodule
bind lps_power_save lps_asserts lps_asserts_i (.*);

/* testbench/tb_lcd_controller_power_save.sv */
// self-checking bench for the lcd power save sequencer
`timescale 1ns/1ns
`include "lps_map.svh"
module tb_lcd_controller_power_save;
  logic       i_mclk = 1'b0, i_pclk = 1'b0, i_rst, i_power_save_en = 1'b0;
  logic       i_indirect_mode = 1'b0, i_cmd_valid = 1'b0, i_display_on = 1'b0;
  logic       i_reg_req = 1'b0, i_mem_req = 1'b0, fs, o_reg_ack, o_mem_ack;
  logic       o_mem_refuse, o_cfg_retain, o_int_clk_en, o_oscillator_run, o_low_power;
  logic       o_panel_display_disable, o_panel_pixel_shift_clock, o_panel_frame_pulse;
  logic       o_panel_line_pulse, o_panel_drive_ready;
  logic [7:0] i_cmd_byte = 8'h00;
  logic [3:0] i_mem_ctrl = 4'h0, o_mem_ctrl, old_ctrl;
  logic [5:0] o_panel_data_bus;
  logic [9:0] gen, g;
  int         miscompares = 0, compares = 0;
  lps_power_save lps_power_save_i (.*, .i_frame_start(fs), .i_gen_shift(gen[9]),
    .i_gen_frame(gen[8]), .i_gen_line(gen[7]), .i_gen_drdy(gen[6]), .i_gen_data(gen[5:0]));
  lps_panel_gen lps_panel_gen_i (.i_pclk(i_pclk), .i_rst(i_rst), .o_frame_start(fs),
    .o_gen(gen));
  always #2 i_mclk = ~i_mclk;
  initial begin
    #13;
    forever #80 i_pclk = ~i_pclk;
  end
  function automatic logic [2:0] acc_exp(input logic lp);
    return {1'b1, ~lp, lp};
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    if (miscompares == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wlp(input logic v);
    int n = 0;
    while (o_low_power !== v && n < 3000) begin
      @(posedge i_mclk);
      n++;
    end
    #1 chk(o_low_power, v);
  endtask
  task automatic acc(input logic lp);
    @(posedge i_mclk);
    i_reg_req <= 1'b1;
    i_mem_req <= 1'b1;
    @(posedge i_mclk);
    i_reg_req <= 1'b0;
    i_mem_req <= 1'b0;
    #1 chk({o_reg_ack, o_mem_ack, o_mem_refuse}, acc_exp(lp));
  endtask
  task automatic cmd(input logic [7:0] b);
    @(posedge i_mclk);
    i_cmd_valid <= 1'b1;
    i_cmd_byte <= b;
    @(posedge i_mclk);
    i_cmd_valid <= 1'b0;
  endtask
  task automatic parked;
    chk({o_panel_display_disable, o_panel_pixel_shift_clock, o_panel_frame_pulse,
      o_panel_line_pulse, o_panel_drive_ready, o_panel_data_bus}, 16'h0000);
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    i_rst <= 1'b1;
    void'($urandom(66403));
    repeat (12) @(posedge i_mclk);
    i_rst <= 1'b0;
    i_display_on <= 1'b1;
    repeat (2) begin
      @(posedge i_mclk);
      old_ctrl = 4'($urandom);
      i_mem_ctrl <= old_ctrl;
      repeat (20) @(posedge i_pclk);
      #1 chk(o_panel_display_disable, 1'b1);
      @(posedge i_pclk);
      g = gen;
      #1 chk({o_panel_pixel_shift_clock, o_panel_frame_pulse, o_panel_line_pulse,
        o_panel_drive_ready, o_panel_data_bus}, {6'h00, g});
      acc(1'b0);
      @(posedge i_mclk);
      i_power_save_en <= 1'b1;
      wlp(1'b1);
      parked();
      chk({o_int_clk_en, o_oscillator_run, o_cfg_retain}, 16'h0001);
      @(posedge i_mclk);
      i_mem_ctrl <= ~old_ctrl;
      acc(1'b1);
      chk(o_mem_ctrl, old_ctrl);
      @(posedge i_mclk);
      i_power_save_en <= 1'b0;
      wlp(1'b0);
      chk({o_int_clk_en, o_oscillator_run, o_cfg_retain}, 16'h0006);
      @(posedge i_mclk);
      #1 chk(o_mem_ctrl, {12'h000, ~old_ctrl});
    end
    cmd(`LPS_CMD_POWER_SAVE);
    repeat (30) @(posedge i_pclk);
    #1 chk(o_low_power, 1'b0);
    @(posedge i_mclk);
    i_indirect_mode <= 1'b1;
    cmd(`LPS_CMD_POWER_SAVE);
    wlp(1'b1);
    cmd(`LPS_CMD_SYSTEM_SET);
    wlp(1'b0);
    @(posedge i_mclk);
    i_display_on <= 1'b0;
    repeat (10) @(posedge i_pclk);
    #1 parked();
    chk({o_oscillator_run, o_int_clk_en}, 16'h0003);
    acc(1'b0);
    close_out();
  end
  initial begin
    #100000;
    miscompares++;
    close_out();
  end
endmodule
